// file: spe_cfg.svh
// Constants of the serial EEPROM command interface.
`ifndef SPE_CFG_SVH
`define SPE_CFG_SVH

// ---------------------------------------------------------------------------
// Instruction codes
// ---------------------------------------------------------------------------
`define SPE_OP_PREFIX 4'h0
`define SPE_OP_ADDR_HI_BIT 3
`define SPE_OP_LATCH_SET 3'h6
`define SPE_OP_LATCH_CLEAR 3'h4
`define SPE_OP_STATUS_READ 3'h5
`define SPE_OP_STATUS_WRITE 3'h1
`define SPE_OP_ARRAY_READ 3'h2
`define SPE_OP_ARRAY_WRITE 3'h3

// ---------------------------------------------------------------------------
// Status byte layout
// ---------------------------------------------------------------------------
`define SPE_SR_BUSY 0
`define SPE_SR_WEL 1
`define SPE_SR_PROT_LO 2
`define SPE_SR_PROT_HI 3
`define SPE_SR_UPPER_FILL 4'hF

// ---------------------------------------------------------------------------
// Block protection
// ---------------------------------------------------------------------------
`define SPE_PROT_NONE 2'h0
`define SPE_PROT_QUARTER 2'h1
`define SPE_PROT_HALF 2'h2
`define SPE_PROT_ALL 2'h3
`define SPE_QUARTER_BASE 9'h180
`define SPE_HALF_BASE 9'h100
`define SPE_PROT_RESET 2'h0

// ---------------------------------------------------------------------------
// Array geometry and timing
// ---------------------------------------------------------------------------
`define SPE_ADDR_W 9
`define SPE_PAGE_W 4
`define SPE_ERASED 8'hFF
`define SPE_BYTE_LAST 3'h7
`define SPE_WRITE_TIME_NS 10000000
`define SPE_CLK_PERIOD_NS 25

`endif

// file: spe_pkg.sv
// Types shared by the serial EEPROM command interface.
package spe_pkg;

  // Position of the serial sequence within one selected frame.
  typedef enum logic [2:0] {
    SPE_LS_CMD,
    SPE_LS_ADDR,
    SPE_LS_RDATA,
    SPE_LS_WDATA,
    SPE_LS_SRDATA,
    SPE_LS_SWDATA,
    SPE_LS_WAIT
  } spe_link_state_t;

  // Kind of self-timed programming cycle in progress.
  typedef enum logic [1:0] {
    SPE_PG_IDLE,
    SPE_PG_ARRAY,
    SPE_PG_STATUS
  } spe_prog_t;

endpackage

// file: spe_sync.sv
// Two-flop level synchroniser used for the control crossings of the block; page, status data and array contents cross without it.
module spe_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic clk,
  // Level from the other domain
  input wire logic [WIDTH-1:0] d,
  // Synchronised level
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // No reset: the value is defined two destination edges after any change.
  always_ff @(posedge clk) begin
    meta_reg <= d;
    sync_reg <= meta_reg;
  end

  assign q = sync_reg;

endmodule // spe_sync

// file: spe_cmd_if.sv
// Serial command interface of a 512-byte EEPROM: decoder, latch, status and array.
`include "spe_cfg.svh"

// What this block does
// - Input bits taken on rising serial clock; output changes after falling edge.
// - Chip select high deselects, output off; standby unless programming runs.
// - Write-protect low refuses every non-volatile write and latch set; other instructions still work.
// - Write-protect falling before final data bit clears latch, no programming.
// - A started programming cycle always runs to its end.
// - Hold low with clock low pauses the sequence; output off meanwhile.
// - Deselect while paused resets serial state; pause persists after reselection.
// - Bytes travel MSB first; first bit on first rising edge after select.
// - Unknown instruction byte makes the device ignore the rest of the frame.
// - Instruction bit 3 is address bit 8 for array read and write.
// - Decode latch set, latch clear and status read codes, bit 3 ignored.
// - Decode status write, array read and array write codes.
// - Array and status writes execute only with the write enable latch set.
// - Latch clears on protect low, power-on, clear, status and array writes.
// - Latch set or clear acts at once, then input ignored until deselect.
// - Protect bits choose blocked range: none, 180h, 100h or 000h up to 1FFh.
// - Status readable anytime; after eight bits output off until deselect.
// - Busy bit shows programming; latch bit shows latch; protect bits writable.
// - During status programming protect bits read their previous values.
// - Status write starts only if chip select rises before seventeenth clock.
// - Array write starts only when chip select rises right after a data byte.
// - Page write loads up to 16 bytes; low address bits wrap in page.
// - Array read streams bytes, address increments and rolls over to zero.
// - Array read during programming is refused; device ignores the frame.
module spe_cmd_if
  import spe_pkg::*;
#(
  parameter int WRITE_CYCLES = `SPE_WRITE_TIME_NS / `SPE_CLK_PERIOD_NS
) (
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link pins from the master
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic hold_n,
  input wire logic wp_n,
  // Serial data output pin
  output logic sdo,
  output logic sdo_oe,
  // Power state
  output logic standby
);

  // ---------------------------------------------------------------------------
  // Geometry and checks
  // ---------------------------------------------------------------------------
  localparam int AW = `SPE_ADDR_W;
  localparam int PW = `SPE_PAGE_W;
  localparam int PAGE_BYTES = 1 << PW;
  localparam int MEM_BYTES = 1 << AW;
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  if (WRITE_CYCLES < 1) begin : g_bad_cycles
    $error("WRITE_CYCLES must be at least one");
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_op(input logic [7:0] code, input logic [2:0] op);
    is_op = (code[7:4] == `SPE_OP_PREFIX) && (code[2:0] == op);
  endfunction

  function automatic logic [7:0] status_byte(input logic busy, input logic write_enable_latch_bit,
                                             input logic [1:0] prot);
    logic [7:0] s;
    s = {`SPE_SR_UPPER_FILL, 4'h0};
    s[`SPE_SR_BUSY] = busy;
    s[`SPE_SR_WEL] = write_enable_latch_bit;
    s[`SPE_SR_PROT_LO] = prot[0];
    s[`SPE_SR_PROT_HI] = prot[1];
    status_byte = s;
  endfunction

  // Pages are aligned, so a page lies wholly inside or outside each range.
  function automatic logic in_protected(input logic [1:0] prot,
                                        input logic [AW-PW-1:0] page);
    logic [AW-1:0] base;
    base = {page, PW'(0)};
    unique case (prot)
      `SPE_PROT_NONE: in_protected = 1'b0;
      `SPE_PROT_QUARTER: in_protected = (base >= `SPE_QUARTER_BASE);
      `SPE_PROT_HALF: in_protected = (base >= `SPE_HALF_BASE);
      `SPE_PROT_ALL: in_protected = 1'b1;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_buf [PAGE_BYTES];

  // Link domain state.
  spe_link_state_t link_state_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic [AW-1:0] addr_reg;
  logic op_write_reg;
  logic [7:0] tx_reg;
  logic set_tgl_reg;
  logic clr_tgl_reg;
  logic wr_arm_reg;
  logic st_arm_reg;
  logic [PAGE_BYTES-1:0] page_mask_reg;
  logic [AW-PW-1:0] page_addr_reg;
  logic [1:0] st_data_reg;
  logic sdo_reg;
  logic sdo_oe_reg;

  // System domain state.
  spe_prog_t prog_reg;
  logic [CNT_W-1:0] timer_reg;
  logic busy_reg;
  logic wel_reg;
  logic ready_reg;
  logic standby_reg;
  logic [1:0] prot_reg;
  logic [1:0] prot_pend_reg;
  logic cs_prev_reg;
  logic set_prev_reg;
  logic clr_prev_reg;

  // ---------------------------------------------------------------------------
  // Crossings
  // ---------------------------------------------------------------------------
  logic busy_l;
  logic wel_l;
  logic ready_l;
  logic [1:0] prot_l;
  logic cs_s;
  logic wp_s;
  logic set_s;
  logic clr_s;
  logic wr_arm_s;
  logic st_arm_s;

  spe_sync #(.WIDTH(5)) u_to_link (
    .clk(sclk),
    .d({busy_reg, wel_reg, ready_reg, prot_reg}),
    .q({busy_l, wel_l, ready_l, prot_l})
  );

  spe_sync #(.WIDTH(6)) u_to_sys (
    .clk(clk),
    .d({cs_n, wp_n, set_tgl_reg, clr_tgl_reg, wr_arm_reg, st_arm_reg}),
    .q({cs_s, wp_s, set_s, clr_s, wr_arm_s, st_arm_s})
  );

  // ---------------------------------------------------------------------------
  // Link domain: frame sequence
  // ---------------------------------------------------------------------------
  logic [7:0] rx_byte;
  logic byte_done;
  logic [AW-1:0] rd_start;

  assign rx_byte = {shift_reg, sdi};
  assign byte_done = (bit_cnt_reg == `SPE_BYTE_LAST);
  assign rd_start = {addr_reg[AW-1], rx_byte};

  // Chip select high clears the whole frame even while paused.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      link_state_reg <= SPE_LS_CMD;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      addr_reg <= '0;
      op_write_reg <= 1'b0;
      tx_reg <= '0;
    end else if (hold_n) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= rx_byte[6:0];
      if (byte_done) begin
        unique case (link_state_reg)
          SPE_LS_CMD: begin
            if (!ready_l) begin
              link_state_reg <= SPE_LS_WAIT;
            end else if (is_op(rx_byte, `SPE_OP_LATCH_SET) ||
                         is_op(rx_byte, `SPE_OP_LATCH_CLEAR)) begin
              link_state_reg <= SPE_LS_WAIT;
            end else if (is_op(rx_byte, `SPE_OP_STATUS_READ)) begin
              tx_reg <= status_byte(busy_l, wel_l, prot_l);
              link_state_reg <= SPE_LS_SRDATA;
            end else if (is_op(rx_byte, `SPE_OP_STATUS_WRITE)) begin
              link_state_reg <= SPE_LS_SWDATA;
            end else if (is_op(rx_byte, `SPE_OP_ARRAY_READ)) begin
              if (busy_l) begin
                link_state_reg <= SPE_LS_WAIT;
              end else begin
                addr_reg[AW-1] <= rx_byte[`SPE_OP_ADDR_HI_BIT];
                op_write_reg <= 1'b0;
                link_state_reg <= SPE_LS_ADDR;
              end
            end else if (is_op(rx_byte, `SPE_OP_ARRAY_WRITE)) begin
              addr_reg[AW-1] <= rx_byte[`SPE_OP_ADDR_HI_BIT];
              op_write_reg <= 1'b1;
              link_state_reg <= SPE_LS_ADDR;
            end else begin
              link_state_reg <= SPE_LS_WAIT;
            end
          end
          SPE_LS_ADDR: begin
            if (op_write_reg) begin
              addr_reg <= rd_start;
              link_state_reg <= SPE_LS_WDATA;
            end else begin
              tx_reg <= mem[rd_start];
              addr_reg <= AW'(rd_start + 1'b1);
              link_state_reg <= SPE_LS_RDATA;
            end
          end
          SPE_LS_RDATA: begin
            tx_reg <= mem[addr_reg];
            addr_reg <= AW'(addr_reg + 1'b1);
          end
          SPE_LS_WDATA: begin
            addr_reg[PW-1:0] <= PW'(addr_reg[PW-1:0] + 1'b1);
          end
          SPE_LS_SRDATA: begin
            link_state_reg <= SPE_LS_WAIT;
          end
          SPE_LS_SWDATA: begin
            link_state_reg <= SPE_LS_WAIT;
          end
          SPE_LS_WAIT: begin
            link_state_reg <= SPE_LS_WAIT;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Link domain: results that must outlive the frame
  // ---------------------------------------------------------------------------
  // These survive the rise of chip select, which is what starts a write.
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      set_tgl_reg <= 1'b0;
      clr_tgl_reg <= 1'b0;
      wr_arm_reg <= 1'b0;
      st_arm_reg <= 1'b0;
      page_mask_reg <= '0;
      page_addr_reg <= '0;
      st_data_reg <= `SPE_PROT_RESET;
    end else if (!cs_n && hold_n) begin
      // Any further clock pulse after a completed byte disarms the write.
      wr_arm_reg <= 1'b0;
      st_arm_reg <= 1'b0;
      if (byte_done && link_state_reg == SPE_LS_CMD && ready_l) begin
        if (is_op(rx_byte, `SPE_OP_LATCH_SET)) begin
          set_tgl_reg <= ~set_tgl_reg;
        end
        if (is_op(rx_byte, `SPE_OP_LATCH_CLEAR)) begin
          clr_tgl_reg <= ~clr_tgl_reg;
        end
      end
      if (byte_done && link_state_reg == SPE_LS_ADDR && op_write_reg) begin
        page_mask_reg <= '0;
        page_addr_reg <= rd_start[AW-1:PW];
      end
      if (byte_done && link_state_reg == SPE_LS_WDATA) begin
        page_mask_reg[addr_reg[PW-1:0]] <= 1'b1;
        wr_arm_reg <= 1'b1;
      end
      if (byte_done && link_state_reg == SPE_LS_SWDATA) begin
        st_data_reg <= rx_byte[`SPE_SR_PROT_HI:`SPE_SR_PROT_LO];
        st_arm_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n && hold_n && byte_done && link_state_reg == SPE_LS_WDATA) begin
      page_buf[addr_reg[PW-1:0]] <= rx_byte;
    end
  end

  // ---------------------------------------------------------------------------
  // Link domain: serial output
  // ---------------------------------------------------------------------------
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else if (hold_n) begin
      sdo_reg <= tx_reg[`SPE_BYTE_LAST - bit_cnt_reg];
      sdo_oe_reg <= (link_state_reg == SPE_LS_RDATA) ||
                    (link_state_reg == SPE_LS_SRDATA);
    end
  end

  // Hold must float the pin at once with the clock stopped, so the enable is
  // gated by the pin itself; the bit in sdo_reg is kept for the resume.
  assign sdo = sdo_reg;
  assign sdo_oe = sdo_oe_reg & hold_n;
  assign standby = standby_reg;

  // ---------------------------------------------------------------------------
  // System domain: frame end and latch
  // ---------------------------------------------------------------------------
  logic cs_rise;
  logic set_ev;
  logic clr_ev;
  logic prog_done;
  logic start_ok;
  logic start_arr;
  logic start_st;

  assign cs_rise = cs_s && !cs_prev_reg;
  assign set_ev = set_s ^ set_prev_reg;
  assign clr_ev = clr_s ^ clr_prev_reg;
  assign prog_done = busy_reg && (timer_reg == '0);
  assign start_ok = cs_rise && ready_reg && wel_reg && wp_s && !busy_reg;
  assign start_arr = start_ok && wr_arm_s &&
                     !in_protected(prot_reg, page_addr_reg);
  assign start_st = start_ok && st_arm_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_prev_reg <= 1'b1;
      set_prev_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_s;
      set_prev_reg <= set_s;
      clr_prev_reg <= clr_s;
      if (cs_s) begin
        ready_reg <= 1'b1;
      end
    end
  end

  // A set arriving with a clear wins; a low protect pin beats both.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wel_reg <= 1'b0;
    end else if (!wp_s) begin
      wel_reg <= 1'b0;
    end else if (set_ev) begin
      wel_reg <= 1'b1;
    end else if (clr_ev || prog_done) begin
      wel_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // System domain: self-timed programming
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prog_reg <= SPE_PG_IDLE;
      busy_reg <= 1'b0;
      timer_reg <= '0;
    end else begin
      unique case (prog_reg)
        SPE_PG_IDLE: begin
          if (start_arr || start_st) begin
            prog_reg <= start_arr ? SPE_PG_ARRAY : SPE_PG_STATUS;
            busy_reg <= 1'b1;
            timer_reg <= CNT_W'(WRITE_CYCLES - 1);
          end
        end
        SPE_PG_ARRAY, SPE_PG_STATUS: begin
          // Neither the protect pin nor the latch can stop a started cycle.
          if (timer_reg == '0) begin
            prog_reg <= SPE_PG_IDLE;
            busy_reg <= 1'b0;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prot_reg <= `SPE_PROT_RESET;
      prot_pend_reg <= `SPE_PROT_RESET;
    end else begin
      if (start_st) begin
        prot_pend_reg <= st_data_reg;
      end
      if (prog_reg == SPE_PG_STATUS && timer_reg == '0) begin
        prot_reg <= prot_pend_reg;
      end
    end
  end

  // Array reads are refused while busy, so writing the page at the start of
  // the cycle cannot be observed early.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= `SPE_ERASED;
      end
    end else if (start_arr) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_mask_reg[i]) begin
          mem[{page_addr_reg, PW'(i)}] <= page_buf[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standby_reg <= 1'b1;
    end else begin
      standby_reg <= cs_s && !busy_reg;
    end
  end

endmodule // spe_cmd_if

// file: spe_cmd_if_monitor.sv
// Concurrent checks on the pins of the serial EEPROM command interface.
`include "spe_cfg.svh"
module spe_cmd_if_monitor #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------------------
  // Edges taken while paused do not count, matching the level-sampled pause.
  logic [4:0] edge_cnt;
  logic [7:0] op;
  logic op_ok;
  logic op_latch;
  logic op_sr;
  logic op_rd;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_cnt <= 5'h00;
    end else if (hold_n && edge_cnt != 5'h1F) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      op <= 8'h00;
    end else if (hold_n && edge_cnt < 5'h08) begin
      op <= {op[6:0], sdi};
    end
  end
  assign op_ok = op[7:4] == `SPE_OP_PREFIX && op[2:0] != 3'h0 && op[2:0] != 3'h7;
  assign op_latch = op_ok && (op[2:0] == `SPE_OP_LATCH_SET || op[2:0] == `SPE_OP_LATCH_CLEAR);
  assign op_sr = op_ok && op[2:0] == `SPE_OP_STATUS_READ;
  assign op_rd = op_ok && op[2:0] == `SPE_OP_ARRAY_READ;
  sequence s_selected;
    $fell(cs_n) ##1 !cs_n [*3];
  endsequence
  chk_oe_deselect: assert property (@(posedge clk) disable iff (sys_rst) cs_n |-> !sdo_oe)
    else $error("output driven while deselected");
  chk_oe_paused: assert property (@(posedge clk) disable iff (sys_rst) !hold_n |-> !sdo_oe)
    else $error("output driven while paused");
  chk_standby_active: assert property (@(posedge clk) disable iff (sys_rst)
    s_selected |-> ##[0:2] !standby) else $error("standby while selected");
  chk_early_quiet: assert property (@(posedge sclk) disable iff (cs_n)
    (edge_cnt < 5'h08 || (op_rd && edge_cnt < 5'h10)) |-> !sdo_oe)
    else $error("output driven before its byte");
  chk_status_drive: assert property (@(posedge sclk) disable iff (cs_n)
    (op_sr && hold_n && edge_cnt >= 5'h08 && edge_cnt <= 5'h0F) |-> sdo_oe)
    else $error("status byte not driven");
  chk_status_done: assert property (@(posedge sclk) disable iff (cs_n)
    (op_sr && edge_cnt >= 5'h10) |-> !sdo_oe) else $error("output after status byte");
  chk_bad_quiet: assert property (@(posedge sclk) disable iff (cs_n)
    (!op_ok && edge_cnt >= 5'h08) |-> !sdo_oe) else $error("unknown code answered");
  chk_latch_quiet: assert property (@(posedge sclk) disable iff (cs_n)
    (op_latch && edge_cnt >= 5'h08) |-> !sdo_oe) else $error("input decoded after latch code");
endmodule // spe_cmd_if_monitor

bind spe_cmd_if spe_cmd_if_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (.clk(clk),
  .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .hold_n(hold_n), .wp_n(wp_n),
  .sdo(sdo), .sdo_oe(sdo_oe), .standby(standby));

// file: spe_master.sv
// Behavioural serial master that drives the link pins of the EEPROM interface.
module spe_master (
  // Link pins driven
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  output logic hold_n,
  // Link pins observed
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cpol;
  logic line;
  int oe_cnt;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    hold_n = 1'b1;
    cpol = 1'b0;
    line = 1'b1;
    oe_cnt = 0;
  end
  task automatic sel();
    // Let a change of idle level settle before select falls, so the
    // mode switch is never taken as a first rising edge of the frame.
    sclk = cpol;
    #10;
    cs_n = 1'b0;
    oe_cnt = 0;
    #30;
  endtask
  // A released output line is modelled as the inverse of its last level.
  task automatic xfer(input logic [7:0] d, input int hold_at, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = d[i];
      if (i == hold_at) begin
        #6 hold_n = 1'b0;
        repeat (3) begin
          #6 sclk = 1'b1;
          #6 sclk = 1'b0;
        end
        #6 hold_n = 1'b1;
      end
      #6;
      line = (sdo_oe === 1'b1) ? sdo : ~line;
      if (sdo_oe === 1'b1) oe_cnt++;
      r[i] = line;
      sclk = 1'b1;
      #6;
    end
  endtask
  task automatic desel();
    if (!cpol) sclk = 1'b0;
    #6 cs_n = 1'b1;
    sdi = ~sdi;
    #160;
  endtask
endmodule // spe_master

// file: tb_spe_cmd_if.sv
// Self-checking bench of the serial EEPROM command interface.
module tb_spe_cmd_if;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WC = 60;
  logic clk, sys_rst, sclk, cs_n, sdi, hold_n, wp_n, sdo, sdo_oe, standby;
  logic [7:0] r;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  spe_cmd_if #(.WRITE_CYCLES(WC)) u_dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .hold_n(hold_n), .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .standby(standby));
  spe_master u_mst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .hold_n(hold_n), .sdo(sdo),
    .sdo_oe(sdo_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The trailing byte must be ignored after a latch code.
  task automatic op1(input logic [7:0] c);
    u_mst.sel();
    u_mst.xfer(c, -1, r);
    u_mst.xfer(8'h05, -1, r);
    u_mst.desel();
  endtask
  task automatic sr(input logic [7:0] exp, input int h);
    u_mst.sel();
    u_mst.xfer(8'h05, -1, r);
    u_mst.xfer(8'hFF, h, r);
    chk("status", exp, r);
    u_mst.xfer(8'hFF, -1, r);
    u_mst.desel();
    chk("drive", 8'h08, 8'(u_mst.oe_cnt));
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200 && standby !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic frame(input logic [7:0] b[$], input logic setl, go, fin);
    if (setl) op1(8'h06);
    u_mst.sel();
    foreach (b[i]) u_mst.xfer(b[i], -1, r);
    u_mst.desel();
    chk("started", {7'h00, go}, {7'h00, ~standby});
    if (fin) wait_idle();
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e[3], input logic ok);
    u_mst.sel();
    u_mst.xfer({4'h0, a[8], 3'h2}, -1, r);
    u_mst.xfer(a[7:0], -1, r);
    foreach (e[i]) begin
      u_mst.xfer(8'h00, -1, r);
      if (ok) chk("array", e[i], r);
    end
    u_mst.desel();
    chk("drive", ok ? 8'h18 : 8'h00, 8'(u_mst.oe_cnt));
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk("standby", 8'h01, {7'h00, standby});
    sr(8'hF0, -1);
    rd(9'h000, '{8'hFF, 8'hFF, 8'hFF}, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_write();
    u_mst.cpol = 1'b1;
    op1(8'h06);
    sr(8'hF2, -1);
    frame('{8'h0B, 8'hA5, 8'h3C}, 1'b0, 1'b1, 1'b0);
    sr(8'hF3, -1);
    rd(9'h1A5, '{8'h00, 8'h00, 8'h00}, 1'b0);
    wait_idle();
    sr(8'hF0, -1);
    rd(9'h1A5, '{8'h3C, 8'hFF, 8'hFF}, 1'b1);
    rd(9'h0A5, '{8'hFF, 8'hFF, 8'hFF}, 1'b1);
    u_mst.cpol = 1'b0;
    $display("test write done");
  endtask
  task automatic t_page();
    logic [7:0] q[$];
    for (int i = 0; i < 17; i++) q.push_back(8'h40 + 8'(i));
    frame({8'h03, 8'h00, q}, 1'b1, 1'b1, 1'b1);
    rd(9'h1FF, '{8'hFF, 8'h50, 8'h41}, 1'b1);
    $display("test page done");
  endtask
  task automatic t_protect();
    logic [8:0] b;
    for (int p = 1; p < 4; p++) begin
      b = 9'(512 - (128 << (p - 1)));
      frame('{8'h01, {4'h0, 2'(p), 2'h0}}, 1'b1, 1'b1, 1'b0);
      sr({4'hF, 2'(p - 1), 2'h3}, -1);
      wait_idle();
      sr({4'hF, 2'(p), 2'h0}, -1);
      frame('{{4'h0, b[8], 3'h3}, b[7:0], 8'h11}, 1'b1, 1'b0, 1'b1);
      b = b - 9'h001;
      frame('{{4'h0, b[8], 3'h3}, b[7:0], 8'h22}, 1'b1, p != 3, 1'b1);
    end
    frame('{8'h01, 8'h00}, 1'b1, 1'b1, 1'b1);
    sr(8'hF0, -1);
    $display("test protect done");
  endtask
  task automatic t_wp();
    @(negedge clk) wp_n = 1'b0;
    op1(8'h06);
    sr(8'hF0, -1);
    frame('{8'h03, 8'h10, 8'h55}, 1'b1, 1'b0, 1'b1);
    @(negedge clk) wp_n = 1'b1;
    fork
      frame('{8'h03, 8'h10, 8'h55}, 1'b1, 1'b0, 1'b1);
      begin
        #450;
        @(negedge clk) wp_n = 1'b0;
        #100;
        @(negedge clk) wp_n = 1'b1;
      end
    join
    sr(8'hF0, -1);
    @(negedge clk) wp_n = 1'b1;
    rd(9'h010, '{8'hFF, 8'hFF, 8'hFF}, 1'b1);
    $display("test protect pin done");
  endtask
  task automatic t_misc();
    logic [7:0] bad[3] = '{8'h00, 8'h07, 8'h85};
    frame('{8'h03, 8'h20}, 1'b1, 1'b0, 1'b1);
    frame('{8'h01, 8'h0C, 8'h00}, 1'b1, 1'b0, 1'b1);
    op1(8'h0C);
    sr(8'hF0, 3);
    op1(8'h0E);
    sr(8'hF2, -1);
    op1(8'h04);
    frame('{8'h03, 8'h30, 8'h77}, 1'b0, 1'b0, 1'b1);
    foreach (bad[i]) begin
      u_mst.sel();
      u_mst.xfer(bad[i], -1, r);
      u_mst.xfer(8'h05, -1, r);
      u_mst.xfer(8'hFF, -1, r);
      u_mst.desel();
      chk("drive", 8'h00, 8'(u_mst.oe_cnt));
    end
    $display("test misc done");
  endtask
  initial begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    t_reset();
    t_write();
    t_page();
    t_protect();
    t_wp();
    t_misc();
    conclude();
  end
endmodule // tb_spe_cmd_if
